// ===== verilog/tpc_map.svh
// register offsets, field positions, reset values and chopper timing for the three-phase pwm block
`ifndef TPC_MAP_SVH
`define TPC_MAP_SVH

// byte offsets on the avalon slave
`define TPC_OFS_CTRL        5'h00
`define TPC_OFS_CHOP        5'h04
`define TPC_OFS_ROUTE       5'h08
`define TPC_OFS_CARRIER     5'h0C
`define TPC_OFS_PHASE_U     5'h10
`define TPC_OFS_PHASE_V     5'h14
`define TPC_OFS_PHASE_W     5'h18
`define TPC_OFS_STATUS      5'h1C

// word index of the first compare register
`define TPC_CMP_BASE_IDX    3'h3

// pwm_control_reg fields
`define TPC_CTRL_CKE        0
`define TPC_CTRL_CENTER     1
`define TPC_CTRL_BYTE       2
`define TPC_CTRL_UPD_TWICE  3
`define TPC_CTRL_PSC_LSB    4
`define TPC_CTRL_OVF_LSB    8
`define TPC_CTRL_RST        32'h0000_0000

// chopper_config_reg fields
`define TPC_CHOP_CH_LSB     0
`define TPC_CHOP_FQ_LSB     2
`define TPC_CHOP_RST        5'h00

// route register fields
`define TPC_ROUTE_3SIG      0
`define TPC_ROUTE_DTE       1
`define TPC_ROUTE_POL_LSB   8
`define TPC_POL_RST         6'h15

// status register fields
`define TPC_STAT_DIR        16
`define TPC_STAT_PWM_LSB    18

// compare reset value
`define TPC_CMP_RST         16'h0000

// chopper half periods in module clocks, one per frequency code
`define TPC_CHOP_HALF_0     7'h50
`define TPC_CHOP_HALF_1     7'h28
`define TPC_CHOP_HALF_2     7'h14
`define TPC_CHOP_HALF_3     7'h10
`define TPC_CHOP_HALF_4     7'h0A
`define TPC_CHOP_HALF_5     7'h08
`define TPC_CHOP_HALF_6     7'h06
`define TPC_CHOP_HALF_7     7'h04

`endif

// ===== verilog/tpc_pkg.sv
// types shared by the three-phase pwm block
package tpc_pkg;
  typedef enum logic [1:0] {
    TPC_UP   = 2'b01,
    TPC_DOWN = 2'b10
  } tpc_dir_e;

  typedef enum logic [1:0] {
    TPC_CHOP_OFF  = 2'b00,
    TPC_CHOP_LOW  = 2'b01,
    TPC_CHOP_HIGH = 2'b10,
    TPC_CHOP_BOTH = 2'b11
  } tpc_chop_e;
endpackage : tpc_pkg

// ===== verilog/tpc_chopper.sv
// high-frequency chopping carrier generator
`include "tpc_map.svh"
module tpc_chopper
  import tpc_pkg::*;
(
  // clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_arst_n,
  // control
  input  wire logic       i_run,
  input  wire logic [2:0] i_chop_freq_sel,
  // carrier
  output logic            o_carrier
);

  logic [6:0] cnt_r;
  logic [6:0] half_nxt;

  function automatic logic [6:0] half_of(input logic [2:0] sel);
    case (sel)
      3'h0:    half_of = `TPC_CHOP_HALF_0;
      3'h1:    half_of = `TPC_CHOP_HALF_1;
      3'h2:    half_of = `TPC_CHOP_HALF_2;
      3'h3:    half_of = `TPC_CHOP_HALF_3;
      3'h4:    half_of = `TPC_CHOP_HALF_4;
      3'h5:    half_of = `TPC_CHOP_HALF_5;
      3'h6:    half_of = `TPC_CHOP_HALF_6;
      default: half_of = `TPC_CHOP_HALF_7;
    endcase
  endfunction : half_of

  assign half_nxt = half_of(i_chop_freq_sel);

  // square carrier
  // equal high and low halves; code 6 gives the 1.33 ratio as 6+6 clocks
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_r     <= 7'h00;
      o_carrier <= 1'b1;
    end else if (!i_run) begin
      cnt_r     <= 7'h00;
      o_carrier <= 1'b1;
    end else if (cnt_r >= half_nxt - 7'h01) begin
      cnt_r     <= 7'h00;
      o_carrier <= ~o_carrier;
    end else begin
      cnt_r     <= cnt_r + 7'h01;
    end
  end

endmodule : tpc_chopper

// ===== verilog/tpc_pwm.sv
// three-phase pwm generator with chopper, avalon-mm register slave
//
// Behaviour
// - two-bit chop_channel_sel: off, low side only, high side only, both sides.
// - three-bit chop_freq_sel picks one of eight chopping carrier frequencies.
// - route off, no complement: polarity register marks each channel high or low side.
// - route off, complement on: even channels high, odd low; selector picks chopped side.
// - three pwm phases u, v, w share one carrier period, separate duties.
// - route off sends only phase u onward; route on sends all three.
// - free-running 12-bit counter, three 13-bit phase compares, 12-bit carrier period.
// - compares are preloaded and copied to active at underflow or overflow, and when clock enable is set.
// - counter ticks through a 3-bit prescaler dividing the clock by one to eight.
// - prescaler setting is buffered and takes effect at the next update event.
// - alignment bit one selects center-aligned counting, zero selects edge-aligned.
// - byte mode: one compare write gives full 8-bit duty range.
// - counter zero-extended to 13 bits is compared with each 13-bit compare.
// - center mode counts up to carrier, down to zero, then up again.
// - center mode: output low on up-count match, high on down-count match.
// - compare above carrier holds output high; compare zero holds it low.
// - edge mode counts up to carrier, clears to zero, counts up again.
// - edge mode: output low on rising match, high when counter clears.
// - clock enable clear holds counter at zero; setting it starts and forces transfer.
//
// Local design decisions: the address map and register access over Avalon-MM.
`include "tpc_map.svh"
module tpc_pwm
  import tpc_pkg::*;
(
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_arst_n,
  // avalon-mm slave
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  // six-step drive from the channel manager
  input  wire logic [5:0]  i_chan_drive,
  // pwm towards input stage and channel manager
  output logic             o_input_stage_pwm,
  output logic [2:0]       o_routed_pwm,
  output logic             o_update_evt,
  output logic             o_three_signal_route,
  output logic             o_deadtime_enable_bit,
  // power stage
  output logic [5:0]       o_motor_channel_out
);

  // register state
  logic        ack_r;
  logic        cke_r;
  logic        cke_q_r;
  logic        center_align_sel_r;
  logic        byte_pwm_sel_r;
  logic        upd_twice_r;
  logic [2:0]  psc_pre_r;
  logic [2:0]  psc_act_r;
  logic [2:0]  ovf_r;
  logic [1:0]  chop_channel_sel_r;
  logic [2:0]  chop_freq_sel_r;
  logic        route_r;
  logic        dte_r;
  logic [5:0]  pol_r;
  logic [15:0] cmp_pre_r [0:3];
  logic [15:0] cmp_rdy_r [0:3];
  logic [12:0] cmp_act_r [0:3];
  // counter state
  logic [2:0]  psc_cnt_r;
  logic [11:0] cnt_r;
  tpc_dir_e    dir_r;
  logic [2:0]  pwm_r;
  logic [5:0]  chan_out_r;
  // combinational
  logic        wr;
  logic        rd;
  logic [2:0]  widx;
  logic        cmp_sel;
  logic [1:0]  cidx;
  logic [15:0] cmp_merged;
  logic        tick;
  logic        at_top;
  logic        at_zero;
  logic        wrap_evt;
  logic        upd;
  logic        carrier;
  logic [5:0]  high_side;
  logic [5:0]  drive;
  logic [5:0]  chop_mask;
  logic [31:0] rdata_nxt;

  // merge a byte-enabled write into a 16-bit compare preload
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  // active compare value from a committed preload
  function automatic logic [12:0] act_of(input logic [15:0] rdy, input logic bytemode,
                                         input logic ovf, input logic carrier_reg);
    if (carrier_reg)
      act_of = bytemode ? {5'h00, rdy[7:0]} : {1'b0, rdy[11:0]};
    else
      act_of = bytemode ? {ovf, 4'h0, rdy[7:0]} : rdy[12:0];
  endfunction : act_of

  // avalon handshake: every access waits exactly one cycle
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_r;
  assign wr      = i_avs_write & ack_r;
  assign rd      = i_avs_read & ~ack_r;
  assign widx    = i_avs_address[4:2];
  assign cmp_sel = (widx >= `TPC_CMP_BASE_IDX) && (widx <= `TPC_CMP_BASE_IDX + 3'h3);
  assign cidx    = 2'(widx - `TPC_CMP_BASE_IDX);
  assign cmp_merged = merge16(cmp_pre_r[cidx], i_avs_writedata, i_avs_byteenable);

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n)
      ack_r <= 1'b0;
    else
      ack_r <= (i_avs_read | i_avs_write) & ~ack_r;
  end

  // control register
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cke_r              <= 1'b0;
      center_align_sel_r <= 1'b0;
      byte_pwm_sel_r     <= 1'b0;
      upd_twice_r        <= 1'b0;
      psc_pre_r          <= 3'h0;
      ovf_r              <= 3'h0;
    end else begin
      if (wr && i_avs_address == `TPC_OFS_CTRL && i_avs_byteenable[0]) begin
        cke_r              <= i_avs_writedata[`TPC_CTRL_CKE];
        center_align_sel_r <= i_avs_writedata[`TPC_CTRL_CENTER];
        byte_pwm_sel_r     <= i_avs_writedata[`TPC_CTRL_BYTE];
        upd_twice_r        <= i_avs_writedata[`TPC_CTRL_UPD_TWICE];
        psc_pre_r          <= i_avs_writedata[`TPC_CTRL_PSC_LSB +: 3];
      end
      // software write beats the hardware clear in the same cycle
      if (wr && i_avs_address == `TPC_OFS_CTRL && i_avs_byteenable[1])
        ovf_r <= i_avs_writedata[`TPC_CTRL_OVF_LSB +: 3];
      else if (upd)
        ovf_r <= 3'h0;
    end
  end

  // chopper and routing registers
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      chop_channel_sel_r <= TPC_CHOP_OFF;
      chop_freq_sel_r    <= 3'h0;
      route_r            <= 1'b0;
      dte_r              <= 1'b0;
      pol_r              <= `TPC_POL_RST;
    end else begin
      if (wr && i_avs_byteenable[0] && i_avs_address == `TPC_OFS_CHOP) begin
        chop_channel_sel_r <= i_avs_writedata[`TPC_CHOP_CH_LSB +: 2];
        chop_freq_sel_r    <= i_avs_writedata[`TPC_CHOP_FQ_LSB +: 3];
      end
      if (wr && i_avs_byteenable[0] && i_avs_address == `TPC_OFS_ROUTE) begin
        route_r <= i_avs_writedata[`TPC_ROUTE_3SIG];
        dte_r   <= i_avs_writedata[`TPC_ROUTE_DTE];
      end
      if (wr && i_avs_byteenable[1] && i_avs_address == `TPC_OFS_ROUTE)
        pol_r <= i_avs_writedata[`TPC_ROUTE_POL_LSB +: 6];
    end
  end

  // compare preloads; reads always return these
  // commit on high byte, or on low byte in byte mode
  // in word mode the ready copy only moves once the high byte lands, so an update between
  // the two byte writes still transfers the previous complete value
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < 4; i++) begin
        cmp_pre_r[i] <= `TPC_CMP_RST;
        cmp_rdy_r[i] <= `TPC_CMP_RST;
      end
    end else if (wr && cmp_sel && i_avs_address[1:0] == 2'b00) begin
      cmp_pre_r[cidx] <= cmp_merged;
      if (byte_pwm_sel_r ? i_avs_byteenable[0] : i_avs_byteenable[1])
        cmp_rdy_r[cidx] <= cmp_merged;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n)
      cke_q_r <= 1'b0;
    else
      cke_q_r <= cke_r;
  end

  assign tick = cke_q_r && (psc_cnt_r == psc_act_r);

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n)
      psc_cnt_r <= 3'h0;
    else if (!cke_q_r || tick || upd)
      psc_cnt_r <= 3'h0;
    else
      psc_cnt_r <= psc_cnt_r + 3'h1;
  end

  assign at_top  = cnt_r >= cmp_act_r[0][11:0];
  assign at_zero = cnt_r == 12'h000;

  // update at underflow or overflow
  // edge mode updates at each clear; center mode at underflow, and also at overflow
  // when the twice-per-period bit is set
  always_comb begin
    wrap_evt = 1'b0;
    if (tick) begin
      if (!center_align_sel_r)
        wrap_evt = at_top;
      else if (dir_r == TPC_DOWN)
        wrap_evt = at_zero;
      else
        wrap_evt = at_top && upd_twice_r;
    end
  end

  assign upd = wrap_evt || (cke_r && !cke_q_r);

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_r <= 12'h000;
      dir_r <= TPC_UP;
    end else if (!cke_q_r) begin
      cnt_r <= 12'h000;
      dir_r <= TPC_UP;
    end else if (tick) begin
      if (!center_align_sel_r) begin
        dir_r <= TPC_UP;
        cnt_r <= at_top ? 12'h000 : cnt_r + 12'h001;
      end else begin
        unique case (dir_r)
          TPC_UP: begin
            if (at_top) begin
              dir_r <= TPC_DOWN;
              cnt_r <= at_zero ? 12'h000 : cnt_r - 12'h001;
            end else begin
              cnt_r <= cnt_r + 12'h001;
            end
          end
          TPC_DOWN: begin
            if (at_zero) begin
              dir_r <= TPC_UP;
              cnt_r <= 12'h001;
            end else begin
              cnt_r <= cnt_r - 12'h001;
            end
          end
          default: begin
            dir_r <= TPC_UP;
            cnt_r <= 12'h000;
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n)
      psc_act_r <= 3'h0;
    else if (upd)
      psc_act_r <= psc_pre_r;
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < 4; i++)
        cmp_act_r[i] <= 13'h0000;
    end else if (upd) begin
      cmp_act_r[0] <= act_of(cmp_rdy_r[0], byte_pwm_sel_r, 1'b0, 1'b1);
      for (int i = 1; i < 4; i++)
        cmp_act_r[i] <= act_of(cmp_rdy_r[i], byte_pwm_sel_r, ovf_r[i-1], 1'b0);
    end
  end

  // full-scale levels
  // high while count is below compare: low at the up-count match, high again at
  // the down-count match or the clear; zero never passes, above carrier always does
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pwm_r <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++)
        pwm_r[i] <= cke_q_r && ({1'b0, cnt_r} < cmp_act_r[i+1]);
    end
  end

  assign o_input_stage_pwm    = pwm_r[0];
  assign o_routed_pwm         = route_r ? pwm_r : {2'b00, pwm_r[0]};
  assign o_update_evt         = upd;
  assign o_three_signal_route = route_r;
  assign o_deadtime_enable_bit = dte_r;

  tpc_chopper u_chopper (
    .i_mclk          (i_mclk),
    .i_arst_n        (i_arst_n),
    .i_run           (chop_channel_sel_r != TPC_CHOP_OFF),
    .i_chop_freq_sel (chop_freq_sel_r),
    .o_carrier       (carrier)
  );

  // channel sides and drive levels
  always_comb begin
    high_side = 6'h00;
    drive     = 6'h00;
    if (route_r || dte_r) begin
      high_side = 6'b01_0101;
    end else begin
      high_side = pol_r;
    end
    if (route_r) begin
      for (int i = 0; i < 3; i++) begin
        drive[2*i]   = pwm_r[i];
        drive[2*i+1] = ~pwm_r[i] & cke_q_r;
      end
    end else begin
      drive = i_chan_drive;
    end
  end

  always_comb begin
    unique case (chop_channel_sel_r)
      TPC_CHOP_OFF:  chop_mask = 6'h00;
      TPC_CHOP_LOW:  chop_mask = ~high_side;
      TPC_CHOP_HIGH: chop_mask = high_side;
      TPC_CHOP_BOTH: chop_mask = 6'h3F;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n)
      chan_out_r <= 6'h00;
    else
      chan_out_r <= drive & (~chop_mask | {6{carrier}});
  end

  assign o_motor_channel_out = chan_out_r;

  // read mux; unmapped offsets read zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (i_avs_address)
      `TPC_OFS_CTRL: begin
        rdata_nxt[`TPC_CTRL_CKE]          = cke_r;
        rdata_nxt[`TPC_CTRL_CENTER]       = center_align_sel_r;
        rdata_nxt[`TPC_CTRL_BYTE]         = byte_pwm_sel_r;
        rdata_nxt[`TPC_CTRL_UPD_TWICE]    = upd_twice_r;
        rdata_nxt[`TPC_CTRL_PSC_LSB +: 3] = psc_pre_r;
        rdata_nxt[`TPC_CTRL_OVF_LSB +: 3] = ovf_r;
      end
      `TPC_OFS_CHOP: begin
        rdata_nxt[`TPC_CHOP_CH_LSB +: 2] = chop_channel_sel_r;
        rdata_nxt[`TPC_CHOP_FQ_LSB +: 3] = chop_freq_sel_r;
      end
      `TPC_OFS_ROUTE: begin
        rdata_nxt[`TPC_ROUTE_3SIG]        = route_r;
        rdata_nxt[`TPC_ROUTE_DTE]         = dte_r;
        rdata_nxt[`TPC_ROUTE_POL_LSB +: 6] = pol_r;
      end
      `TPC_OFS_CARRIER: rdata_nxt[15:0] = cmp_pre_r[0];
      `TPC_OFS_PHASE_U: rdata_nxt[15:0] = cmp_pre_r[1];
      `TPC_OFS_PHASE_V: rdata_nxt[15:0] = cmp_pre_r[2];
      `TPC_OFS_PHASE_W: rdata_nxt[15:0] = cmp_pre_r[3];
      `TPC_OFS_STATUS: begin
        rdata_nxt[11:0]                    = cnt_r;
        rdata_nxt[`TPC_STAT_DIR]           = (dir_r == TPC_DOWN);
        rdata_nxt[`TPC_STAT_PWM_LSB +: 3]  = pwm_r;
      end
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n)
      o_avs_readdata <= 32'h0000_0000;
    else if (rd)
      o_avs_readdata <= rdata_nxt;
  end

endmodule : tpc_pwm

// ===== test/tpc_pwm_assertions.sv
// port-level assertions for the three-phase pwm block
`include "tpc_map.svh"
module tpc_pwm_checker
  import tpc_pkg::*;
(
  // clock and reset
  input wire logic        i_mclk,
  input wire logic        i_arst_n,
  // avalon-mm slave
  input wire logic [4:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0]  i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  // channel drive and outputs
  input wire logic [5:0]  i_chan_drive,
  input wire logic        o_input_stage_pwm,
  input wire logic [2:0]  o_routed_pwm,
  input wire logic        o_update_evt,
  input wire logic        o_three_signal_route,
  input wire logic        o_deadtime_enable_bit,
  input wire logic [5:0]  o_motor_channel_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] chop_q;
  logic       en_q;
  logic       wr_tk;
  logic       rd_tk;
  assign wr_tk = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
  assign rd_tk = i_avs_read && !o_avs_waitrequest;
  // shadow of the chopper side select, the outputs do not show it
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) chop_q <= 2'h0;
    else if (wr_tk && i_avs_address == `TPC_OFS_CHOP) chop_q <= i_avs_writedata[1:0];
  end
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) en_q <= 1'b0;
    else if (wr_tk && i_avs_address == `TPC_OFS_CTRL) en_q <= i_avs_writedata[0];
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  sequence req_rise;
    $rose(i_avs_read || i_avs_write);
  endsequence
  sequence one_wait;
    o_avs_waitrequest ##1 !o_avs_waitrequest;
  endsequence
  wait_once_a:
    assert property (req_rise |-> one_wait) else $error("access not answered after one wait");
  idle_nowait_a:
    assert property (!(i_avs_read || i_avs_write) |-> !o_avs_waitrequest) else $error("wait without request");
  unmapped_zero_a:
    assert property (rd_tk && i_avs_address[1:0] != 2'h0 |-> o_avs_readdata == 32'h0)
      else $error("unmapped read not zero");
  enable_update_a:
    assert property (wr_tk && i_avs_address == `TPC_OFS_CTRL && i_avs_writedata[0] && !en_q |=> o_update_evt)
      else $error("no update on enable");
  update_pulse_a:
    assert property (o_update_evt |=> !o_update_evt) else $error("update longer than one cycle");
  route_flag_a:
    assert property (wr_tk && i_avs_address == `TPC_OFS_ROUTE |=> o_three_signal_route == $past(i_avs_writedata[0]))
      else $error("route bit not stored");
  route_u_only_a:
    assert property (!o_three_signal_route && !$past(o_three_signal_route)
      |-> o_routed_pwm == {2'h0, o_input_stage_pwm}) else $error("route off passes v or w");
  pair_route_a:
    // odd channels are held low while the counter is stopped
    assert property (o_three_signal_route && chop_q == TPC_CHOP_OFF && $past(en_q) |=> o_motor_channel_out ==
      {~$past(o_routed_pwm[2]), $past(o_routed_pwm[2]), ~$past(o_routed_pwm[1]), $past(o_routed_pwm[1]),
       ~$past(o_routed_pwm[0]), $past(o_routed_pwm[0])}) else $error("complementary pairs wrong");
  drive_pass_a:
    assert property (!o_three_signal_route && !o_deadtime_enable_bit && chop_q == TPC_CHOP_OFF
      |=> o_motor_channel_out == $past(i_chan_drive)) else $error("channel drive not passed");
endmodule : tpc_pwm_checker

bind tpc_pwm tpc_pwm_checker tpc_pwm_checker_inst (
  .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .i_chan_drive(i_chan_drive),
  .o_input_stage_pwm(o_input_stage_pwm), .o_routed_pwm(o_routed_pwm), .o_update_evt(o_update_evt),
  .o_three_signal_route(o_three_signal_route), .o_deadtime_enable_bit(o_deadtime_enable_bit),
  .o_motor_channel_out(o_motor_channel_out));

// ===== test/tpc_stage_model.sv
// channel manager and power stage model at the far side of the pwm block
module tpc_stage_model (
  // clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_arst_n,
  // six-step pattern commanded by the bench, and the motor channels from the pwm block
  input  wire logic [5:0] i_pattern,
  input  wire logic [5:0] i_motor,
  // drive towards the pwm block, overlap flag to the bench
  output logic [5:0]      o_drive,
  output logic            o_overlap
);
  timeunit 1ns;
  timeprecision 100ps;
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) o_drive <= 6'h00;
    else o_drive <= i_pattern;
  end
  // both switches of a half bridge on is shoot-through
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) o_overlap <= 1'b0;
    else if ((i_motor[0] & i_motor[1]) | (i_motor[2] & i_motor[3]) | (i_motor[4] & i_motor[5])) o_overlap <= 1'b1;
  end
endmodule : tpc_stage_model

// ===== test/tpc_pwm_tb_top.sv
// self-checking bench for the three-phase pwm block
`include "tpc_map.svh"
module tpc_pwm_tb_top;
  import tpc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    logic        w;
    logic [4:0]  a;
    logic [31:0] d;
    logic [31:0] e;
  } tpc_row_s;
  logic        i_mclk           = 1'b0;
  logic        i_arst_n         = 1'b0;
  logic [4:0]  i_avs_address    = 5'h00;
  logic        i_avs_read       = 1'b0;
  logic        i_avs_write      = 1'b0;
  logic [31:0] i_avs_writedata  = 32'h0;
  logic [3:0]  i_avs_byteenable = 4'h0;
  logic [5:0]  pattern          = 6'h00;
  logic [31:0] o_avs_readdata;
  logic        o_avs_waitrequest;
  logic [5:0]  chan_drive;
  logic        o_input_stage_pwm;
  logic [2:0]  o_routed_pwm;
  logic [5:0]  o_motor_channel_out;
  logic        overlap;
  logic [8:0]  obs;
  int          bad_count = 0;
  int          checks    = 0;
  // reset reads first, then write and read back; last rows leave route on, chopper off
  tpc_row_s rows [12] = '{
    '{1'b0, 5'h00, 32'h0, 32'h0}, '{1'b0, 5'h04, 32'h0, 32'h0}, '{1'b0, 5'h08, 32'h0, 32'h1500},
    '{1'b0, 5'h1C, 32'h0, 32'h0}, '{1'b1, 5'h0C, 32'h8, 32'h8}, '{1'b1, 5'h10, 32'h4, 32'h4},
    '{1'b1, 5'h14, 32'h0, 32'h0}, '{1'b1, 5'h18, 32'h9, 32'h9}, '{1'b1, 5'h04, 32'h1F, 32'h1F},
    '{1'b1, 5'h04, 32'h0, 32'h0}, '{1'b1, 5'h03, 32'hFFFF, 32'h0}, '{1'b1, 5'h08, 32'h1501, 32'h1501}};
  int half [8] = '{`TPC_CHOP_HALF_0, `TPC_CHOP_HALF_1, `TPC_CHOP_HALF_2, `TPC_CHOP_HALF_3,
                   `TPC_CHOP_HALF_4, `TPC_CHOP_HALF_5, `TPC_CHOP_HALF_6, `TPC_CHOP_HALF_7};
  int sel_hi [4] = '{80, 80, 40, 40};
  assign obs = {o_routed_pwm, o_motor_channel_out};

  tpc_pwm tpc_pwm_inst (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .i_chan_drive(chan_drive),
    .o_input_stage_pwm(o_input_stage_pwm), .o_routed_pwm(o_routed_pwm), .o_update_evt(),
    .o_three_signal_route(), .o_deadtime_enable_bit(), .o_motor_channel_out(o_motor_channel_out));
  tpc_stage_model tpc_stage_model_inst (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_pattern(pattern), .i_motor(o_motor_channel_out),
    .o_drive(chan_drive), .o_overlap(overlap));

  initial begin
    forever #5 i_mclk = ~i_mclk;
  end

  task automatic finish_test();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk

  // one avalon access; the request stands until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_mclk);
    i_avs_read       <= !w;
    i_avs_write      <= w;
    i_avs_address    <= a;
    i_avs_writedata  <= d;
    i_avs_byteenable <= be;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 50);
    q = o_avs_readdata;
    i_avs_read  <= 1'b0;
    i_avs_write <= 1'b0;
    if (o_avs_waitrequest !== 1'b0) begin
      bad_count++;
      finish_test();
    end
  endtask : bus

  // count high cycles of one observed output after the period settles
  task automatic meas(input int b, input int n, input int e);
    int c;
    c = 0;
    repeat (20) @(posedge i_mclk);
    repeat (n) begin
      @(negedge i_mclk);
      c += (obs[b] === 1'b1) ? 1 : 0;
    end
    chk(c, e);
  endtask : meas

  initial begin
    logic [31:0] q;
    repeat (16) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) bus(1'b1, rows[i].a, rows[i].d, 4'h3, q);
      bus(1'b0, rows[i].a, 32'h0, 4'hF, q);
      chk(q, rows[i].e);
    end
    // edge mode, carrier 8: u=4 high 4 of 9, v=0 low, w above carrier high
    bus(1'b1, 5'h00, 32'h1, 4'h3, q);
    meas(6, 90, 40);
    meas(7, 90, 0);
    meas(8, 90, 90);
    bus(1'b1, 5'h00, 32'h0, 4'h3, q);
    bus(1'b1, 5'h00, 32'h3, 4'h3, q);
    meas(6, 160, 70);
    bus(1'b1, 5'h00, 32'h0, 4'h3, q);
    // the counter clears two clocks after the enable drops
    repeat (2) @(posedge i_mclk);
    bus(1'b0, 5'h1C, 32'h0, 4'hF, q);
    chk(q & 32'hFFF, 32'h0);
    // divide by two doubles the period
    bus(1'b1, 5'h00, 32'h11, 4'h3, q);
    meas(6, 180, 80);
    // preload taken at update; low lane alone does not commit
    bus(1'b1, 5'h00, 32'h0, 4'h3, q);
    bus(1'b1, 5'h00, 32'h1, 4'h3, q);
    bus(1'b1, 5'h10, 32'h6, 4'h3, q);
    meas(6, 90, 60);
    bus(1'b1, 5'h10, 32'h2, 4'h1, q);
    meas(6, 90, 60);
    bus(1'b1, 5'h10, 32'h2, 4'h3, q);
    meas(6, 90, 20);
    // every side select at the fastest carrier, u held high
    bus(1'b1, 5'h10, 32'h9, 4'h3, q);
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, 5'h04, 32'h1C | s, 4'h3, q);
      meas(0, 80, sel_hi[s]);
    end
    for (int f = 0; f < 8; f++) begin
      bus(1'b1, 5'h04, (f << 2) | 2, 4'h3, q);
      meas(0, 8 * half[f], 4 * half[f]);
    end
    // route off: polarity register, or the complement bit when set, decides which side is chopped
    pattern <= 6'h09;
    bus(1'b1, 5'h08, 32'h1500, 4'h3, q);
    bus(1'b1, 5'h04, 32'h1D, 4'h3, q);
    meas(3, 80, 40);
    meas(0, 80, 80);
    bus(1'b1, 5'h08, 32'h2A00, 4'h3, q);
    meas(0, 80, 40);
    bus(1'b1, 5'h08, 32'h2A02, 4'h3, q);
    meas(0, 80, 80);
    chk({31'h0, overlap}, 32'h0);
    // byte mode: one low-lane write commits phase u
    bus(1'b1, 5'h00, 32'h0, 4'h3, q);
    bus(1'b1, 5'h00, 32'h5, 4'h3, q);
    bus(1'b1, 5'h10, 32'h3, 4'h1, q);
    meas(6, 90, 30);
    // mid-run reset stops the counter and clears the outputs
    i_arst_n <= 1'b0;
    repeat (2) @(posedge i_mclk);
    chk({23'h0, obs}, 32'h0);
    i_arst_n <= 1'b1;
    bus(1'b0, 5'h1C, 32'h0, 4'hF, q);
    chk(q, 32'h0);
    finish_test();
  end
endmodule : tpc_pwm_tb_top
